// ===== rtl/acl_action_defines.svh
// constants for the access-list action decoder: register offsets, field positions,
// reset values and special action codes
// assumes inclusion by bare name from the package and design files
`ifndef ACL_ACTION_DEFINES_SVH
`define ACL_ACTION_DEFINES_SVH

`define ADR_IP_SWAP_CTRL 8'h00
`define ADR_STATUS 8'h04
`define ADR_SIP_BASE 8'h80
`define IPC_TTL_LSB 0
`define IPC_TTL_W 8
`define IPC_BITCNT_LSB 8
`define IPC_BITCNT_W 6
`define IPC_RST 32'h0000_3040
`define MODE_REPL_DMAC 4'h8
`define MAC_W 48
`define SIP_ENTRIES 32

`endif

// ===== rtl/acl_action_pkg.sv
// types shared by the access-list action decoder
// assumes the defines header sits next to it
`include "acl_action_defines.svh"
package acl_action_pkg;

  typedef enum logic [1:0] {
    PTP_NONE = 2'h0,
    PTP_ONE_STEP = 2'h1,
    PTP_TWO_STEP = 2'h2,
    PTP_TOD = 2'h3
  } ptp_cmd_t;

  typedef enum logic [1:0] {
    DLY_NONE = 2'h0,
    DLY_EGRESS = 2'h1,
    DLY_INGRESS_A = 2'h2,
    DLY_INGRESS_B = 2'h3
  } delay_cmd_t;

  // swap-mode actions; *_mc / *_uc variants are conditional on the frame's addresses
  typedef struct packed {
    logic dmac_repl;
    logic smac_repl;
    logic mac_swap;
    logic mac_swap_uc;
    logic smac_repl_mc;
    logic smac_repl_dmac_mc;
    logic ip_swap;
    logic ip_swap_uc;
    logic sip_repl_mc;
    logic sip_repl_dip_mc;
  } swap_t;

  typedef struct packed {
    logic valid;
    logic [7:0] rw_cmd;
    ptp_cmd_t ptp;
    delay_cmd_t dly;
    logic seq_fill;
    logic dly_resp_proc;
    logic receipt_upd;
    logic dmac_from_smac;
    logic smac_from_port;
    logic ttl_dec;
    logic ttl_preset;
    logic [7:0] ttl_value;
    logic uc_route;
    logic mc_route;
    logic mac_field_ovl;
    swap_t swp;
    logic [47:0] repl_mac;
    logic [47:0] dmac_mask;
    logic [31:0] sip;
    logic pol_ovr;
    logic [5:0] pol_idx;
    logic dlb_ena;
    logic [9:0] dlb_idx;
    logic port_rw;
    logic [15:0] dst_port;
    logic [15:0] src_port;
    logic cpu_tag_valid;
    logic [15:0] class_result;
    logic [11:0] cnt_idx;
    logic log_int_valid;
    logic [3:0] log_int;
    logic [1:0] time_dom;
  } cmd_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [31:0] ipc;
    logic [31:0] frames;
    logic [31:0][31:0] sip_tbl;
    cmd_t cmd;
  } state_t;

endpackage

// ===== rtl/acl_action_decoder.sv
// decoder for the action word of a matched access-list rule; registered commands
// for the frame rewriter and routing update stages
// assumes action inputs come from logic on clk_i and a classic wishbone master
`timescale 1ns/10ps
`default_nettype none
`include "acl_action_defines.svh"

module acl_action_decoder
  import acl_action_pkg::*;
#(
  parameter int SIP_N = `SIP_ENTRIES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic act_valid_i,
  input wire logic [7:0] rewrite_command_i,
  input wire logic hop_count_update_flag_i,
  input wire logic service_activation_only_flag_i,
  input wire logic service_activation_sequence_class_i,
  input wire logic port_rewrite_flag_i,
  input wire logic [15:0] entry_logical_tag_i,
  input wire logic [15:0] entry_tag_mask_i,
  input wire logic [11:0] counter_index_i,
  input wire logic mac_swap_flag_i,
  input wire logic [2:0] interval_field_i,
  input wire logic [3:0] routing_swap_mode_i,
  input wire logic [47:0] replacement_mac_field_i,
  input wire logic [1:0] time_domain_selector_i,
  input wire logic [4:0] policer_index_i,
  input wire logic cpu_copy_flag_i,
  output logic cmd_valid_o,
  output logic [7:0] rewrite_command_o,
  output logic [1:0] ptp_cmd_o,
  output logic [1:0] delay_cmd_o,
  output logic seq_fill_o,
  output logic dly_resp_proc_o,
  output logic receipt_update_o,
  output logic dmac_from_smac_o,
  output logic smac_from_port_o,
  output logic ttl_decrement_o,
  output logic ttl_preset_o,
  output logic [7:0] ttl_value_o,
  output logic uc_route_o,
  output logic mc_route_o,
  output logic mac_field_overload_o,
  output logic [9:0] swap_actions_o,
  output logic [47:0] repl_mac_o,
  output logic [47:0] dmac_repl_mask_o,
  output logic [31:0] repl_sip_o,
  output logic pol_ctrl_override_o,
  output logic [5:0] pol_ctrl_idx_o,
  output logic dlb_enable_o,
  output logic [9:0] dlb_index_o,
  output logic port_rewrite_o,
  output logic [15:0] dst_port_o,
  output logic [15:0] src_port_o,
  output logic cpu_tag_valid_o,
  output logic [15:0] classification_result_o,
  output logic [11:0] counter_index_o,
  output logic log_interval_valid_o,
  output logic [3:0] log_interval_o,
  output logic [1:0] time_domain_o
);

  state_t st_ff;
  state_t nxt_st;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                              input logic [31:0] dat,
                                              input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = dat[8*b +: 8];
      end
    end
    return r;
  endfunction

  // ones in the top cnt bits; counts above the width saturate to all ones
  function automatic logic [47:0] msb_mask(input logic [5:0] cnt);
    logic [47:0] m;
    m = '0;
    for (int i = 0; i < `MAC_W; i++) begin
      m[`MAC_W-1-i] = (i < int'(cnt));
    end
    return m;
  endfunction

  function automatic swap_t swap_decode(input logic [2:0] sub);
    swap_t s;
    s = '0;
    unique case (sub)
      3'h0: s.dmac_repl = 1'b1;
      3'h1: s.smac_repl = 1'b1;
      3'h2: begin
        s.mac_swap = 1'b1;
        s.smac_repl_mc = 1'b1;
      end
      3'h3: begin
        s.mac_swap_uc = 1'b1;
        s.smac_repl_dmac_mc = 1'b1;
      end
      3'h4: begin
        s.mac_swap = 1'b1;
        s.smac_repl_mc = 1'b1;
        s.ip_swap = 1'b1;
        s.sip_repl_mc = 1'b1;
      end
      3'h5: begin
        s.mac_swap_uc = 1'b1;
        s.smac_repl_dmac_mc = 1'b1;
        s.ip_swap_uc = 1'b1;
        s.sip_repl_dip_mc = 1'b1;
      end
      3'h6: begin
        s.ip_swap = 1'b1;
        s.sip_repl_mc = 1'b1;
      end
      3'h7: begin
        s.smac_repl = 1'b1;
        s.ip_swap = 1'b1;
        s.sip_repl_mc = 1'b1;
      end
    endcase
    return s;
  endfunction

  logic [3:0] mode_eff;
  logic repl_dmac_mode;
  logic [7:0] fwd_cmd;

  always_comb begin
    repl_dmac_mode = (routing_swap_mode_i == `MODE_REPL_DMAC);
    // the flag is reinterpreted in replace-dmac mode, so it does not zero the mode there
    mode_eff = (service_activation_only_flag_i && !service_activation_sequence_class_i
                && !repl_dmac_mode) ? 4'h0 : routing_swap_mode_i;
    fwd_cmd = rewrite_command_i;
    if (rewrite_command_i[5]) begin
      fwd_cmd[5:4] = 2'h0;
    end
  end

  always_comb begin
    nxt_st = st_ff;
    // one wait state; the guard on ack drops it in the cycle after it was given
    nxt_st.ack = wb_cyc_i & wb_stb_i & ~st_ff.ack;
    nxt_st.rdat = 32'h0000_0000;
    // writes land at the edge where the master samples ack high, not one edge early
    if (wb_cyc_i && wb_stb_i && wb_we_i && st_ff.ack) begin
      if (wb_adr_i == `ADR_IP_SWAP_CTRL) begin
        nxt_st.ipc = merge_bytes(st_ff.ipc, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i[7]) begin
        nxt_st.sip_tbl[wb_adr_i[6:2]] = merge_bytes(st_ff.sip_tbl[wb_adr_i[6:2]],
                                                    wb_dat_i, wb_sel_i);
      end
    end
    if (nxt_st.ack && !wb_we_i) begin
      if (wb_adr_i == `ADR_IP_SWAP_CTRL) begin
        nxt_st.rdat = st_ff.ipc;
      end else if (wb_adr_i == `ADR_STATUS) begin
        nxt_st.rdat = st_ff.frames;
      end else if (wb_adr_i[7]) begin
        nxt_st.rdat = st_ff.sip_tbl[wb_adr_i[6:2]];
      end
    end

    nxt_st.cmd.valid = act_valid_i;
    if (act_valid_i) begin
      nxt_st.frames = st_ff.frames + 32'h0000_0001;
      nxt_st.cmd.rw_cmd = fwd_cmd;
      nxt_st.cmd.ptp = ptp_cmd_t'(rewrite_command_i[1:0]);
      nxt_st.cmd.dly = delay_cmd_t'(rewrite_command_i[3:2]);
      nxt_st.cmd.seq_fill = (rewrite_command_i[5:4] == 2'h1);
      nxt_st.cmd.dly_resp_proc = rewrite_command_i[5];
      nxt_st.cmd.receipt_upd = (rewrite_command_i[5:4] == 2'h2);
      nxt_st.cmd.dmac_from_smac = rewrite_command_i[6];
      nxt_st.cmd.smac_from_port = rewrite_command_i[7];
      nxt_st.cmd.ttl_preset = hop_count_update_flag_i & mode_eff[3] & mode_eff[2];
      nxt_st.cmd.ttl_dec = hop_count_update_flag_i & ~(mode_eff[3] & mode_eff[2]);
      nxt_st.cmd.ttl_value = st_ff.ipc[`IPC_TTL_LSB +: `IPC_TTL_W];
      nxt_st.cmd.uc_route = ~mode_eff[3] & mode_eff[0];
      nxt_st.cmd.mc_route = ~mode_eff[3] & mode_eff[1];
      nxt_st.cmd.mac_field_ovl = (mode_eff[3:2] == 2'h1);
      nxt_st.cmd.swp = mode_eff[3] ? swap_decode(mode_eff[2:0]) : '0;
      // plain mac swap only while bit 5 leaves the flag its first meaning
      nxt_st.cmd.swp.mac_swap = nxt_st.cmd.swp.mac_swap |
                                (mac_swap_flag_i & ~rewrite_command_i[5]);
      nxt_st.cmd.repl_mac = replacement_mac_field_i;
      nxt_st.cmd.dmac_mask = (repl_dmac_mode && service_activation_only_flag_i) ?
          msb_mask(st_ff.ipc[`IPC_BITCNT_LSB +: `IPC_BITCNT_W]) : '1;
      nxt_st.cmd.sip = st_ff.sip_tbl[policer_index_i];
      nxt_st.cmd.pol_ovr = (mode_eff[3:2] == 2'h1) & replacement_mac_field_i[0];
      nxt_st.cmd.pol_idx = replacement_mac_field_i[6:1];
      nxt_st.cmd.dlb_ena = (mode_eff[3:2] == 2'h1) & replacement_mac_field_i[16];
      nxt_st.cmd.dlb_idx = replacement_mac_field_i[26:17];
      nxt_st.cmd.port_rw = port_rewrite_flag_i;
      nxt_st.cmd.dst_port = entry_logical_tag_i;
      nxt_st.cmd.src_port = entry_tag_mask_i;
      nxt_st.cmd.cpu_tag_valid = cpu_copy_flag_i;
      nxt_st.cmd.class_result = cpu_copy_flag_i ? entry_logical_tag_i : 16'h0000;
      nxt_st.cmd.cnt_idx = counter_index_i;
      nxt_st.cmd.log_int_valid = rewrite_command_i[5];
      // two's complement: the swap flag acts as the sign bit, giving value minus 8
      nxt_st.cmd.log_int = {mac_swap_flag_i, interval_field_i};
      nxt_st.cmd.time_dom = time_domain_selector_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
      st_ff.ipc <= `IPC_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wb_ack_o = st_ff.ack;
  assign wb_dat_o = st_ff.rdat;
  assign cmd_valid_o = st_ff.cmd.valid;
  assign rewrite_command_o = st_ff.cmd.rw_cmd;
  assign ptp_cmd_o = st_ff.cmd.ptp;
  assign delay_cmd_o = st_ff.cmd.dly;
  assign seq_fill_o = st_ff.cmd.seq_fill;
  assign dly_resp_proc_o = st_ff.cmd.dly_resp_proc;
  assign receipt_update_o = st_ff.cmd.receipt_upd;
  assign dmac_from_smac_o = st_ff.cmd.dmac_from_smac;
  assign smac_from_port_o = st_ff.cmd.smac_from_port;
  assign ttl_decrement_o = st_ff.cmd.ttl_dec;
  assign ttl_preset_o = st_ff.cmd.ttl_preset;
  assign ttl_value_o = st_ff.cmd.ttl_value;
  assign uc_route_o = st_ff.cmd.uc_route;
  assign mc_route_o = st_ff.cmd.mc_route;
  assign mac_field_overload_o = st_ff.cmd.mac_field_ovl;
  assign swap_actions_o = st_ff.cmd.swp;
  assign repl_mac_o = st_ff.cmd.repl_mac;
  assign dmac_repl_mask_o = st_ff.cmd.dmac_mask;
  assign repl_sip_o = st_ff.cmd.sip;
  assign pol_ctrl_override_o = st_ff.cmd.pol_ovr;
  assign pol_ctrl_idx_o = st_ff.cmd.pol_idx;
  assign dlb_enable_o = st_ff.cmd.dlb_ena;
  assign dlb_index_o = st_ff.cmd.dlb_idx;
  assign port_rewrite_o = st_ff.cmd.port_rw;
  assign dst_port_o = st_ff.cmd.dst_port;
  assign src_port_o = st_ff.cmd.src_port;
  assign cpu_tag_valid_o = st_ff.cmd.cpu_tag_valid;
  assign classification_result_o = st_ff.cmd.class_result;
  assign counter_index_o = st_ff.cmd.cnt_idx;
  assign log_interval_valid_o = st_ff.cmd.log_int_valid;
  assign log_interval_o = st_ff.cmd.log_int;
  assign time_domain_o = st_ff.cmd.time_dom;

  property p_ptp;
    @(posedge clk_i) disable iff (rst_i)
    act_valid_i |=> cmd_valid_o && ptp_cmd_o == $past(rewrite_command_i[1:0]);
  endproperty
  a_ptp: assert property (p_ptp) else $error("ptp command mismatch");

  property p_delay;
    @(posedge clk_i) disable iff (rst_i)
    act_valid_i |=> delay_cmd_o == $past(rewrite_command_i[3:2]);
  endproperty
  a_delay: assert property (p_delay) else $error("delay command mismatch");

  property p_seq_clear;
    @(posedge clk_i) disable iff (rst_i)
    act_valid_i && rewrite_command_i[5] |=> rewrite_command_o[5:4] == 2'h0 &&
        dly_resp_proc_o && !seq_fill_o;
  endproperty
  a_seq_clear: assert property (p_seq_clear) else $error("bits 5:4 not cleared");

  property p_mac_bits;
    @(posedge clk_i) disable iff (rst_i)
    act_valid_i |=> {smac_from_port_o, dmac_from_smac_o} == $past(rewrite_command_i[7:6]);
  endproperty
  a_mac_bits: assert property (p_mac_bits) else $error("mac rewrite bits wrong");

  property p_ttl;
    @(posedge clk_i) disable iff (rst_i)
    act_valid_i && hop_count_update_flag_i |=> ttl_decrement_o != ttl_preset_o;
  endproperty
  a_ttl: assert property (p_ttl) else $error("ttl update ambiguous");

  property p_sam;
    @(posedge clk_i) disable iff (rst_i)
    act_valid_i && service_activation_only_flag_i && !service_activation_sequence_class_i
        |=> swap_actions_o == {7'h00, 3'h0} || !$past(routing_swap_mode_i[3]) ||
            $past(routing_swap_mode_i) == `MODE_REPL_DMAC || $past(mac_swap_flag_i);
  endproperty
  a_sam: assert property (p_sam) else $error("mode applied to non-sam frame");

  property p_port;
    @(posedge clk_i) disable iff (rst_i)
    act_valid_i && port_rewrite_flag_i |=> port_rewrite_o &&
        dst_port_o == $past(entry_logical_tag_i) && src_port_o == $past(entry_tag_mask_i);
  endproperty
  a_port: assert property (p_port) else $error("port rewrite values wrong");

  property p_cnt;
    @(posedge clk_i) disable iff (rst_i)
    act_valid_i |=> counter_index_o == $past(counter_index_i) ##1
        (cmd_valid_o || counter_index_o == $past(counter_index_o));
  endproperty
  a_cnt: assert property (p_cnt) else $error("counter index not held");

  property p_interval;
    @(posedge clk_i) disable iff (rst_i)
    act_valid_i && rewrite_command_i[5] |=> log_interval_valid_o &&
        $signed(log_interval_o) == ($past(mac_swap_flag_i) ?
        $signed({1'b0, $past(interval_field_i)}) - 4'sh8 :
        $signed({1'b0, $past(interval_field_i)}));
  endproperty
  a_interval: assert property (p_interval) else $error("log interval wrong");

  property p_ack;
    @(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus ack timing wrong");

  property p_class;
    @(posedge clk_i) disable iff (rst_i)
    act_valid_i |=> cpu_tag_valid_o == $past(cpu_copy_flag_i) &&
        classification_result_o == ($past(cpu_copy_flag_i) ? $past(entry_logical_tag_i) :
        16'h0000);
  endproperty
  a_class: assert property (p_class) else $error("classification result wrong");

  property p_route;
    @(posedge clk_i) disable iff (rst_i)
    act_valid_i && !service_activation_only_flag_i && !routing_swap_mode_i[3] |=>
        uc_route_o == $past(routing_swap_mode_i[0]) &&
        mc_route_o == $past(routing_swap_mode_i[1]);
  endproperty
  a_route: assert property (p_route) else $error("routing enables wrong");

  c_two_step: cover property (@(posedge clk_i) disable iff (rst_i)
      act_valid_i && rewrite_command_i[1:0] == 2'h2);
  c_swap_ip: cover property (@(posedge clk_i) disable iff (rst_i)
      act_valid_i && routing_swap_mode_i == 4'hc && hop_count_update_flag_i);
  c_dmac_mask: cover property (@(posedge clk_i) disable iff (rst_i)
      act_valid_i && repl_dmac_mode && service_activation_only_flag_i);
  c_bus_write: cover property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o && wb_we_i);

endmodule
`default_nettype wire

// ===== testbench/rewriter_model.sv
// model of the downstream rewriter: takes each decoded command on its valid pulse
// assumes the decoder's registered outputs on the same clock, sync reset
`timescale 1ns/10ps
`default_nettype none
module rewriter_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cmd_valid_i,
  input wire logic [7:0] rewrite_command_i,
  output logic [15:0] frames_seen_o,
  output logic [7:0] last_cmd_o
);
  // counts levels, not pulses, so a valid held two cycles counts as two frames
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frames_seen_o <= 16'h0000;
      last_cmd_o <= 8'h00;
    end else if (cmd_valid_i === 1'b1) begin
      frames_seen_o <= frames_seen_o + 16'h0001;
      last_cmd_o <= rewrite_command_i;
    end
  end
endmodule
`default_nettype wire

// ===== testbench/tb.sv
// self-checking bench for the access-list action decoder and its rewriter model
// assumes classic wishbone answers and a one-cycle action path as handed over
`timescale 1ns/10ps
`default_nettype none
module tb;
  import acl_action_pkg::*;
  typedef struct packed {
    logic [7:0] cmd; logic hop; logic sam_only; logic sam_cls; logic prw;
    logic [15:0] tag; logic [15:0] msk; logic [11:0] cnt; logic swf; logic [2:0] itv;
    logic [3:0] mode; logic [47:0] mac; logic [1:0] dom; logic [4:0] pol; logic cpu;
  } act_in_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdv;
  logic wb_ack_o, act_valid_i = 1'b0;
  act_in_t a = '0, d = '0;
  logic cmd_valid_o, seq_fill_o, dly_resp_proc_o, receipt_update_o, dmac_from_smac_o;
  logic smac_from_port_o, ttl_decrement_o, ttl_preset_o, uc_route_o, mc_route_o;
  logic mac_field_overload_o, pol_ctrl_override_o, dlb_enable_o, port_rewrite_o;
  logic cpu_tag_valid_o, log_interval_valid_o;
  logic [7:0] rewrite_command_o, ttl_value_o, last_cmd;
  logic [1:0] ptp_cmd_o, delay_cmd_o, time_domain_o;
  logic [9:0] swap_actions_o, dlb_index_o;
  logic [47:0] repl_mac_o, dmac_repl_mask_o;
  logic [31:0] repl_sip_o;
  logic [5:0] pol_ctrl_idx_o;
  logic [15:0] dst_port_o, src_port_o, classification_result_o, frames_seen;
  logic [11:0] counter_index_o;
  logic [3:0] log_interval_o;
  logic [9:0] sw [8] = '{10'h200, 10'h100, 10'h0a0, 10'h050, 10'h0aa, 10'h055, 10'h00a,
                         10'h10a};
  int fail_count = 0, n_compared = 0, n_frames = 0, cyc_cnt = 0;

  acl_action_decoder u_acl_action_decoder (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .act_valid_i(act_valid_i), .rewrite_command_i(d.cmd), .hop_count_update_flag_i(d.hop),
    .service_activation_only_flag_i(d.sam_only),
    .service_activation_sequence_class_i(d.sam_cls), .port_rewrite_flag_i(d.prw),
    .entry_logical_tag_i(d.tag), .entry_tag_mask_i(d.msk), .counter_index_i(d.cnt),
    .mac_swap_flag_i(d.swf), .interval_field_i(d.itv), .routing_swap_mode_i(d.mode),
    .replacement_mac_field_i(d.mac), .time_domain_selector_i(d.dom),
    .policer_index_i(d.pol), .cpu_copy_flag_i(d.cpu), .cmd_valid_o(cmd_valid_o),
    .rewrite_command_o(rewrite_command_o), .ptp_cmd_o(ptp_cmd_o), .delay_cmd_o(delay_cmd_o),
    .seq_fill_o(seq_fill_o), .dly_resp_proc_o(dly_resp_proc_o),
    .receipt_update_o(receipt_update_o), .dmac_from_smac_o(dmac_from_smac_o),
    .smac_from_port_o(smac_from_port_o), .ttl_decrement_o(ttl_decrement_o),
    .ttl_preset_o(ttl_preset_o), .ttl_value_o(ttl_value_o), .uc_route_o(uc_route_o),
    .mc_route_o(mc_route_o), .mac_field_overload_o(mac_field_overload_o),
    .swap_actions_o(swap_actions_o), .repl_mac_o(repl_mac_o),
    .dmac_repl_mask_o(dmac_repl_mask_o), .repl_sip_o(repl_sip_o),
    .pol_ctrl_override_o(pol_ctrl_override_o), .pol_ctrl_idx_o(pol_ctrl_idx_o),
    .dlb_enable_o(dlb_enable_o), .dlb_index_o(dlb_index_o), .port_rewrite_o(port_rewrite_o),
    .dst_port_o(dst_port_o), .src_port_o(src_port_o), .cpu_tag_valid_o(cpu_tag_valid_o),
    .classification_result_o(classification_result_o), .counter_index_o(counter_index_o),
    .log_interval_valid_o(log_interval_valid_o), .log_interval_o(log_interval_o),
    .time_domain_o(time_domain_o));

  rewriter_model u_rewriter_model (.clk_i(clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_o),
    .rewrite_command_i(rewrite_command_o), .frames_seen_o(frames_seen), .last_cmd_o(last_cmd));

  always #50 clk_i = ~clk_i;

  task automatic report_and_stop();
    if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // generous ceiling: the whole sequence needs under 2000 cycles
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      fail_count++;
      $display("MISMATCH t=%0t timeout", $time);
      report_and_stop();
    end
  end

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                    input logic [3:0] sel, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1);
    chk(wb_ack_o, 1'b1);
    chk(n, 2); // ack is seen on the second edge after the request
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // load hands the action word over at a rising edge; the next edge takes it
  task automatic load();
    @(posedge clk_i);
    act_valid_i <= 1'b1;
    d <= a;
    n_frames++;
  endtask

  task automatic fire();
    load();
    @(posedge clk_i);
    act_valid_i <= 1'b0;
    @(negedge clk_i);
    chk(cmd_valid_o, 1'b1);
  endtask

  task automatic t_regs();
    wb(1'b0, 8'h00, 32'h0, 4'hf, rdv);
    chk(rdv, 32'h0000_3040);
    wb(1'b1, 8'h04, 32'hffff_ffff, 4'hf, rdv);
    wb(1'b0, 8'h04, 32'h0, 4'hf, rdv);
    chk(rdv, 32'h0);
    wb(1'b0, 8'h44, 32'h0, 4'hf, rdv);
    chk(rdv, 32'h0);
    wb(1'b1, 8'h00, 32'hffff_ff22, 4'h1, rdv);
    wb(1'b0, 8'h00, 32'h0, 4'hf, rdv);
    chk(rdv, 32'h0000_3022);
  endtask

  task automatic t_cmd();
    logic [7:0] c;
    for (int i = 0; i < 256; i++) begin
      c = i[7:0];
      a.cmd = c;
      fire();
      chk(rewrite_command_o, c[5] ? (c & 8'hcf) : c);
      chk(ptp_cmd_o, c[1:0]);
      chk(delay_cmd_o, c[3:2]);
      chk(seq_fill_o, c[5:4] == 2'h1);
      chk(dly_resp_proc_o, c[5]);
      chk(receipt_update_o, c[5:4] == 2'h2);
      chk(dmac_from_smac_o, c[6]);
      chk(smac_from_port_o, c[7]);
      chk(log_interval_valid_o, c[5]);
    end
    @(negedge clk_i);
    chk(last_cmd, 8'hcf);
    a = '0;
  endtask

  task automatic t_swap();
    a.hop = 1'b1;
    a.mac = 48'h0123_4567_89ab;
    fire();
    chk(ttl_decrement_o, 1'b1);
    chk(ttl_preset_o, 1'b0);
    for (int m = 0; m < 8; m++) begin
      a.mode = 4'h8 | m[3:0];
      fire();
      chk(ttl_preset_o, m >= 4);
      chk(ttl_decrement_o, m < 4);
      if (m >= 4) chk(ttl_value_o, 8'h22);
      chk(swap_actions_o, sw[m]);
      chk(repl_mac_o, 48'h0123_4567_89ab);
      chk(dmac_repl_mask_o, 48'hffff_ffff_ffff);
    end
    a = '0;
  endtask

  task automatic t_route();
    a.mac = 48'h0000_058b_0055;
    for (int m = 0; m < 8; m++) begin
      a.mode = m[3:0];
      fire();
      chk(uc_route_o, m[0]);
      chk(mc_route_o, m[1]);
      chk(swap_actions_o, 10'h000);
      chk(mac_field_overload_o, m[2]);
      if (m[2]) begin
        chk({pol_ctrl_override_o, pol_ctrl_idx_o}, 7'h6a);
        chk({dlb_enable_o, dlb_index_o}, 11'h6c5);
      end
    end
    a = '0;
  endtask

  task automatic t_sam();
    a.sam_only = 1'b1;
    a.mode = 4'h1;
    fire();
    chk(uc_route_o, 1'b0);
    a.mode = 4'h9;
    fire();
    chk(swap_actions_o, 10'h000);
    a.mode = 4'h1;
    a.sam_cls = 1'b1;
    fire();
    chk(uc_route_o, 1'b1);
    wb(1'b1, 8'h00, 32'h0000_0400, 4'h2, rdv);
    a.sam_cls = 1'b0;
    a.mode = 4'h8;
    fire();
    chk(dmac_repl_mask_o, 48'hf000_0000_0000);
    chk(swap_actions_o, 10'h200);
    a = '0;
  endtask

  task automatic t_fields();
    wb(1'b1, 8'h8c, 32'hc0a8_0103, 4'hf, rdv);
    a = '{cmd: 8'h20, prw: 1'b1, tag: 16'hbeef, msk: 16'h1234, cnt: 12'hfff, swf: 1'b1,
          itv: 3'h3, dom: 2'h3, pol: 5'h03, cpu: 1'b1, default: '0};
    fire();
    chk({port_rewrite_o, dst_port_o}, 17'h1beef);
    chk(src_port_o, 16'h1234);
    chk({cpu_tag_valid_o, classification_result_o}, 17'h1beef);
    chk(counter_index_o, 12'hfff);
    chk(time_domain_o, 2'h3);
    chk(repl_sip_o, 32'hc0a8_0103);
    chk(log_interval_o, 4'hb);
    chk(swap_actions_o, 10'h000);
    a.cpu = 1'b0;
    a.itv = 3'h0;
    fire();
    chk(classification_result_o, 16'h0000);
    chk(log_interval_o, 4'h8);
    a.cmd = 8'h00;
    fire();
    chk(swap_actions_o, 10'h080);
    a = '0;
  endtask

  task automatic t_b2b();
    a.cnt = 12'h001;
    load();
    a.cnt = 12'h002;
    load();
    @(negedge clk_i);
    chk({cmd_valid_o, counter_index_o}, 13'h1001);
    @(posedge clk_i);
    act_valid_i <= 1'b0;
    @(negedge clk_i);
    chk({cmd_valid_o, counter_index_o}, 13'h1002);
    @(negedge clk_i);
    chk({cmd_valid_o, counter_index_o}, 13'h0002);
    chk(frames_seen, n_frames);
    wb(1'b0, 8'h04, 32'h0, 4'hf, rdv);
    chk(rdv, n_frames);
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_cmd();
    t_swap();
    t_route();
    t_sam();
    t_fields();
    t_b2b();
    report_and_stop();
  end
endmodule
`default_nettype wire
